// [rtl/spi_guard_pkg.sv]
package spi_guard_pkg;

   // frame layout of the guarded word write, in shift order
   localparam int CMD_BITS  = 4;
   localparam int ADDR_BITS = 12;
   localparam int BYTE_BITS = 8;
   localparam int WORD_BYTES = 4;
   localparam int WORD_BITS = WORD_BYTES * BYTE_BITS;
   localparam int CRC_BITS  = 16;
   localparam int FRAME_LEN = CMD_BITS + ADDR_BITS + WORD_BITS + CRC_BITS;
   localparam int CNT_BITS  = 7;

   localparam logic [CMD_BITS-1:0] CMD_GUARDED_WRITE = 4'hc;

   // bit counts reached after the command, data and checksum fields
   localparam logic [CNT_BITS-1:0] CMD_DONE_CNT  = 7'(CMD_BITS);
   localparam logic [CNT_BITS-1:0] DATA_DONE_CNT = 7'(CMD_BITS + ADDR_BITS + WORD_BITS);
   localparam logic [CNT_BITS-1:0] FRAME_CNT     = 7'(FRAME_LEN);

   // field positions inside the full frame shift register
   localparam int FLD_CRC_LSB  = 0;
   localparam int FLD_DATA_LSB = CRC_BITS;
   localparam int FLD_ADDR_LSB = CRC_BITS + WORD_BITS;

   localparam logic [ADDR_BITS-1:0] ADDR_ALIGN_MASK = 12'hffc;

   localparam logic [CRC_BITS-1:0] CRC_INIT = 16'hffff;
   localparam logic [CRC_BITS-1:0] CRC_POLY = 16'h8005;

endpackage

// [rtl/crc16_serial.sv]
`timescale 1ns/1ps
`default_nettype none

module crc16_serial
   import spi_guard_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                restart,
   input  wire logic                enable,
   input  wire logic                bitIn,
   output logic [CRC_BITS-1:0]      crcVal
);

   logic [CRC_BITS-1:0] crcFf;
   logic [CRC_BITS-1:0] nxt_crc;
   logic [CRC_BITS-1:0] seed;
   logic                feedback;

   always_comb begin
      seed     = restart ? CRC_INIT : crcFf;
      feedback = seed[CRC_BITS-1] ^ bitIn;
      nxt_crc  = crcFf;
      if (enable) begin
         // msb-first shift, generator applied on feedback
         nxt_crc = {seed[CRC_BITS-2:0], 1'b0} ^ (feedback ? CRC_POLY : '0);
      end
   end

   always_ff @(posedge clk) begin
      crcFf <= nxt_crc;
   end

   assign crcVal = crcFf;

endmodule // crc16_serial

`default_nettype wire

// [rtl/spi_guarded_word_write.sv]
// Overview of operation
// - frame opens with command 0xc then a 12-bit RAM address.
// - four data bytes follow, addressed A to A+3, forming one word.
// - a 16-bit checksum follows, upper byte first, captured for comparison.
// - chip select rising ends the command.
// - the word is written to RAM only after a matching checksum.
// - on mismatch RAM is untouched and the mismatch flag is set.
// - chip select rising after the command but before the checksum ends sets truncation flag, no write.
// - the checksum accumulator starts at all ones at each frame.
// - checksum is CRC-16 with generator 0x8005, same at both ends.
// - on mismatch the computed checksum is kept in the status output.
// - the two low address bits are forced to zero.
`timescale 1ns/1ps
`default_nettype none

module spi_guarded_word_write
   import spi_guard_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  spiClk,
   input  wire logic                  chipSelectN,
   input  wire logic                  sdi,
   input  wire logic                  clearMismatch,
   input  wire logic                  clearTruncated,
   output logic                       ramWrEn,
   output logic [ADDR_BITS-1:0]       ramAddr,
   output logic [WORD_BITS-1:0]       ramWrData,
   output logic                       checksumMismatchFlag,
   output logic                       truncatedTransactionFlag,
   output logic [CRC_BITS-1:0]        crcStatus
);

   // ---------------- link side, on the serial clock ----------------
   logic                    armedFf;
   logic [CNT_BITS-1:0]     bitCntFf;
   logic [CNT_BITS-1:0]     nxt_bitCnt;
   logic [FRAME_LEN-1:0]    frameShFf;
   logic [FRAME_LEN-1:0]    nxt_frameSh;
   logic [CMD_BITS-1:0]     cmdFf;
   logic [CMD_BITS-1:0]     nxt_cmd;
   logic [CNT_BITS-1:0]     curCnt;
   logic                    crcEnable;
   logic [CRC_BITS-1:0]     crcCalc;

   // armed drops at once when the frame ends; its clear is a constant
   always_ff @(posedge spiClk or posedge chipSelectN) begin
      if (chipSelectN) begin
         armedFf <= 1'b0;
      end else begin
         armedFf <= 1'b1;
      end
   end

   always_comb begin
      // first edge of a frame counts from zero
      curCnt      = armedFf ? bitCntFf : '0;
      nxt_bitCnt  = curCnt;
      nxt_frameSh = frameShFf;
      nxt_cmd     = cmdFf;
      if (curCnt < FRAME_CNT) begin
         nxt_bitCnt  = curCnt + 7'(1);
         nxt_frameSh = {frameShFf[FRAME_LEN-2:0], sdi};
      end
      if (nxt_bitCnt == CMD_DONE_CNT && curCnt < CMD_DONE_CNT) begin
         nxt_cmd = {frameShFf[CMD_BITS-2:0], sdi};
      end
      crcEnable = curCnt < DATA_DONE_CNT;
   end

   // no reset: the bit count restarts at the first edge of every frame, and all three then
   // stay still once the serial clock stops, so the core reads them quietly
   always_ff @(posedge spiClk) begin
      bitCntFf  <= nxt_bitCnt;
      frameShFf <= nxt_frameSh;
      cmdFf     <= nxt_cmd;
   end

   crc16_serial uCrc (
      .clk     (spiClk),
      .restart (~armedFf),
      .enable  (crcEnable),
      .bitIn   (sdi),
      .crcVal  (crcCalc)
   );

   // ---------------- core side, on clk ----------------
   logic                    csMetaFf;
   logic                    csSyncFf;
   logic                    csPrevFf;
   logic                    armedMetaFf;
   logic                    armedSyncFf;
   logic                    hadEdgesFf;
   logic                    nxt_csMeta;
   logic                    nxt_csSync;
   logic                    nxt_csPrev;
   logic                    nxt_armedMeta;
   logic                    nxt_armedSync;
   logic                    nxt_hadEdges;

   logic                    endEvt;
   logic                    isGuarded;
   logic                    complete;
   logic                    crcOk;
   logic [ADDR_BITS-1:0]    rxAddr;
   logic [WORD_BITS-1:0]    rxWord;
   logic [CRC_BITS-1:0]     rxCrc;

   logic                    ramWrEnFf;
   logic [ADDR_BITS-1:0]    ramAddrFf;
   logic [WORD_BITS-1:0]    ramWrDataFf;
   logic                    mismatchFf;
   logic                    truncFf;
   logic [CRC_BITS-1:0]     crcStatusFf;
   logic                    nxt_ramWrEn;
   logic [ADDR_BITS-1:0]    nxt_ramAddr;
   logic [WORD_BITS-1:0]    nxt_ramWrData;
   logic                    nxt_mismatch;
   logic                    nxt_trunc;
   logic [CRC_BITS-1:0]     nxt_crcStatus;

   always_comb begin
      nxt_csMeta    = chipSelectN;
      nxt_csSync    = csMetaFf;
      nxt_csPrev    = csSyncFf;
      nxt_armedMeta = armedFf;
      nxt_armedSync = armedMetaFf;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         csMetaFf    <= 1'b1;
         csSyncFf    <= 1'b1;
         csPrevFf    <= 1'b1;
         armedMetaFf <= 1'b0;
         armedSyncFf <= 1'b0;
      end else begin
         csMetaFf    <= nxt_csMeta;
         csSyncFf    <= nxt_csSync;
         csPrevFf    <= nxt_csPrev;
         armedMetaFf <= nxt_armedMeta;
         armedSyncFf <= nxt_armedSync;
      end
   end

   always_comb begin
      // a frame without serial edges leaves stale link state; never act on it
      endEvt       = csSyncFf & ~csPrevFf & hadEdgesFf;
      nxt_hadEdges = hadEdgesFf | (armedSyncFf & ~csSyncFf);
      if (endEvt) begin
         nxt_hadEdges = 1'b0;
      end
      isGuarded = (bitCntFf >= CMD_DONE_CNT) && (cmdFf == CMD_GUARDED_WRITE);
      complete  = bitCntFf == FRAME_CNT;
      rxAddr    = frameShFf[FLD_ADDR_LSB +: ADDR_BITS] & ADDR_ALIGN_MASK;
      rxCrc     = frameShFf[FLD_CRC_LSB +: CRC_BITS];
      rxWord    = '0;
      // first byte on the wire lands at the lowest byte address
      for (int i = 0; i < WORD_BYTES; i++) begin
         rxWord[i*BYTE_BITS +: BYTE_BITS] =
            frameShFf[FLD_DATA_LSB + (WORD_BYTES-1-i)*BYTE_BITS +: BYTE_BITS];
      end
      crcOk = crcCalc == rxCrc;
   end

   always_comb begin
      nxt_ramWrEn   = 1'b0;
      nxt_ramAddr   = ramAddrFf;
      nxt_ramWrData = ramWrDataFf;
      nxt_crcStatus = crcStatusFf;
      // software clear loses against a new event in the same cycle
      nxt_mismatch  = mismatchFf & ~clearMismatch;
      nxt_trunc     = truncFf & ~clearTruncated;
      if (endEvt && isGuarded) begin
         if (!complete) begin
            nxt_trunc = 1'b1;
         end else if (crcOk) begin
            nxt_ramWrEn   = 1'b1;
            nxt_ramAddr   = rxAddr;
            nxt_ramWrData = rxWord;
         end else begin
            nxt_mismatch  = 1'b1;
            nxt_crcStatus = crcCalc;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         hadEdgesFf  <= 1'b0;
         ramWrEnFf   <= 1'b0;
         ramAddrFf   <= '0;
         ramWrDataFf <= '0;
         mismatchFf  <= 1'b0;
         truncFf     <= 1'b0;
         crcStatusFf <= '0;
      end else begin
         hadEdgesFf  <= nxt_hadEdges;
         ramWrEnFf   <= nxt_ramWrEn;
         ramAddrFf   <= nxt_ramAddr;
         ramWrDataFf <= nxt_ramWrData;
         mismatchFf  <= nxt_mismatch;
         truncFf     <= nxt_trunc;
         crcStatusFf <= nxt_crcStatus;
      end
   end

   assign ramWrEn                  = ramWrEnFf;
   assign ramAddr                  = ramAddrFf;
   assign ramWrData                = ramWrDataFf;
   assign checksumMismatchFlag     = mismatchFf;
   assign truncatedTransactionFlag = truncFf;
   assign crcStatus                = crcStatusFf;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence goodEnd;
      endEvt && isGuarded && complete && crcOk;
   endsequence

   sequence badEnd;
      endEvt && isGuarded && complete && !crcOk;
   endsequence

   sequence shortEnd;
      endEvt && isGuarded && !complete;
   endsequence

   AST_COMMIT_ON_MATCH: assert property (
      goodEnd |=> ramWrEn && ramWrData == $past(rxWord) && ramAddr == $past(rxAddr)
   ) else $error("matching frame did not commit its word");

   AST_NO_WRITE_ON_MISMATCH: assert property (
      badEnd |=> !ramWrEn && checksumMismatchFlag ##1 !ramWrEn
   ) else $error("mismatching frame wrote RAM or left flag clear");

   AST_TRUNC_FLAG: assert property (
      shortEnd |=> truncatedTransactionFlag && !ramWrEn
   ) else $error("short frame not flagged or was committed");

   AST_STATUS_HOLDS_CALC: assert property (
      badEnd |=> crcStatus == $past(crcCalc)
   ) else $error("status lacks computed checksum after mismatch");

   AST_ALIGNED_ADDR: assert property (
      ramWrEn |-> ramAddr[1:0] == 2'h0
   ) else $error("unaligned RAM address written");

   AST_WRITE_ONLY_AT_END: assert property (
      ramWrEn |-> $past(endEvt) && $past(csSyncFf) && !$past(csPrevFf)
   ) else $error("RAM write not caused by end of frame");

   AST_OTHER_CMD_IGNORED: assert property (
      endEvt && !isGuarded && !clearMismatch && !clearTruncated |=>
         !ramWrEn && $stable(checksumMismatchFlag) && $stable(truncatedTransactionFlag)
   ) else $error("foreign command changed state");

   AST_FLAG_STICKY: assert property (
      checksumMismatchFlag && !clearMismatch |=> checksumMismatchFlag
   ) else $error("mismatch flag dropped without clear");

   AST_CRC_STARTS_AT_ONES: assert property (
      @(posedge spiClk) disable iff (chipSelectN)
      !armedFf |=> crcCalc ==
         ({CRC_INIT[CRC_BITS-2:0], 1'b0} ^ ($past(sdi) ? '0 : CRC_POLY))
   ) else $error("checksum did not restart from all ones");

   AST_CRC_EXCLUDES_ITSELF: assert property (
      @(posedge spiClk) disable iff (chipSelectN)
      armedFf && bitCntFf >= DATA_DONE_CNT |=> $stable(crcCalc)
   ) else $error("checksum moved during checksum field");

   // the RAM port takes exactly one write per good frame
   AST_WREN_ONE_CYCLE: assert property (
      ramWrEn |=> !ramWrEn
   ) else $error("RAM write strobe longer than one cycle");

   AST_WORD_HELD: assert property (
      !ramWrEn |-> $stable(ramAddr) && $stable(ramWrData)
   ) else $error("RAM address or word moved without a write");

   AST_STATUS_KEPT_ON_MATCH: assert property (
      goodEnd |=> $stable(crcStatus) && $stable(checksumMismatchFlag)
   ) else $error("matching frame touched checksum status");

   AST_MISMATCH_CLEARS: assert property (
      clearMismatch && !(endEvt && isGuarded && complete && !crcOk) |=> !checksumMismatchFlag
   ) else $error("mismatch flag survived its clear");

   AST_TRUNC_STICKY: assert property (
      truncatedTransactionFlag && !clearTruncated |=> truncatedTransactionFlag
   ) else $error("truncation flag dropped without clear");

   AST_TRUNC_CLEARS: assert property (
      clearTruncated && !(endEvt && isGuarded && !complete) |=> !truncatedTransactionFlag
   ) else $error("truncation flag survived its clear");

   // a short frame has no checksum to judge, so mismatch state must not move
   AST_TRUNC_NOT_MISMATCH: assert property (
      endEvt && isGuarded && !complete && !clearMismatch |=>
         $stable(checksumMismatchFlag) && $stable(crcStatus)
   ) else $error("short frame changed mismatch state");

endmodule // spi_guarded_word_write

`default_nettype wire

// [verif/spi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module spi_host_model
   import spi_guard_pkg::*;
(
   output logic spiClk,
   output logic chipSelectN,
   output logic sdi
);
   // select starts low and rises at 1 ns: the link's armed flop clears only on
   // a rising select edge, and a select high from time zero would give none
   initial begin
      spiClk      = 1'b0;
      chipSelectN = 1'b0;
      sdi         = 1'b0;
      #1 chipSelectN = 1'b1;
   end

   // first data byte goes to the addressed byte, lowest byte of the word
   function automatic logic [47:0] pack(input logic [3:0] cmd, input logic [11:0] addr,
                                        input logic [31:0] w);
      return {cmd, addr, w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   function automatic logic [CRC_BITS-1:0] crc16(input logic [47:0] msg);
      logic [CRC_BITS-1:0] c;
      logic                fb;
      c = CRC_INIT;
      for (int i = 47; i >= 0; i--) begin
         fb = c[15] ^ msg[i];
         c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

   // clock runs only inside the frame, 12 ns period, mode 0
   task automatic send(input logic [3:0] cmd, input logic [11:0] addr, input logic [31:0] w,
                       input logic [15:0] flip, input int nbits);
      logic [63:0] frame;
      frame = {pack(cmd, addr, w), crc16(pack(cmd, addr, w)) ^ flip};
      #6 chipSelectN = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi = frame[63-i];
         #6 spiClk = 1'b1;
         #6 spiClk = 1'b0;
      end
      #6 chipSelectN = 1'b1;
      sdi = ~sdi; // released line must not look like held data
   endtask
endmodule // spi_host_model

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import spi_guard_pkg::*;
   logic                 clk;
   logic                 rstn;
   logic                 clearMismatch;
   logic                 clearTruncated;
   logic                 spiClk;
   logic                 chipSelectN;
   logic                 sdi;
   logic                 ramWrEn;
   logic [ADDR_BITS-1:0] ramAddr;
   logic [WORD_BITS-1:0] ramWrData;
   logic                 checksumMismatchFlag;
   logic                 truncatedTransactionFlag;
   logic [CRC_BITS-1:0]  crcStatus;
   int                   bad_count = 0;
   int                   checks = 0;
   int                   wrCount;

   always #10 clk = ~clk;

   spi_guarded_word_write u_dut (
      .clk(clk), .rstn(rstn), .spiClk(spiClk), .chipSelectN(chipSelectN), .sdi(sdi),
      .clearMismatch(clearMismatch), .clearTruncated(clearTruncated), .ramWrEn(ramWrEn),
      .ramAddr(ramAddr), .ramWrData(ramWrData), .checksumMismatchFlag(checksumMismatchFlag),
      .truncatedTransactionFlag(truncatedTransactionFlag), .crcStatus(crcStatus));

   spi_host_model u_host (.spiClk(spiClk), .chipSelectN(chipSelectN), .sdi(sdi));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // 12 core cycles cover the answer latency and the required idle gap
   task automatic frame(input logic [3:0] cmd, input logic [11:0] a, input logic [31:0] w,
                        input logic [15:0] flip, input int nbits);
      u_host.send(cmd, a, w, flip, nbits);
      wrCount = 0;
      repeat (12) begin
         @(posedge clk);
         #1;
         if (ramWrEn !== 1'b0) wrCount++;
      end
   endtask

   task automatic clear_flags();
      @(posedge clk);
      clearMismatch  <= 1'b1;
      clearTruncated <= 1'b1;
      @(posedge clk);
      clearMismatch  <= 1'b0;
      clearTruncated <= 1'b0;
      @(posedge clk);
      #1;
      check(checksumMismatchFlag, 0);
      check(truncatedTransactionFlag, 0);
   endtask

   task automatic t_good();
      frame(4'hc, 12'h3a7, 32'h44332211, 16'h0000, 64);
      check(wrCount, 1);
      check(ramAddr, 12'h3a4);
      check(ramWrData, 32'h44332211);
      frame(4'hc, 12'hffe, 32'hdeadbeef, 16'h0000, 64);
      check(wrCount, 1);
      check({ramAddr, ramWrData[19:0]}, 32'hffcdbeef);
      check(checksumMismatchFlag, 0);
      $display("test good frames done");
   endtask

   task automatic t_bad();
      frame(4'hc, 12'h120, 32'h0f0f55aa, 16'h0100, 64);
      check(wrCount, 0);
      check(checksumMismatchFlag, 1);
      check(crcStatus, u_host.crc16(u_host.pack(4'hc, 12'h120, 32'h0f0f55aa)));
      check(ramAddr, 12'hffc);
      clear_flags();
      $display("test checksum mismatch done");
   endtask

   task automatic t_trunc();
      int n[3] = '{56, 63, 20};
      foreach (n[i]) begin
         frame(4'hc, 12'h040, 32'h12345678, 16'h0000, n[i]);
         check(wrCount, 0);
         check(truncatedTransactionFlag, 1);
         check(checksumMismatchFlag, 0);
         clear_flags();
      end
      $display("test truncated frames done");
   endtask

   task automatic t_other();
      frame(4'ha, 12'h200, 32'h0badf00d, 16'h0000, 64);
      check(wrCount, 0);
      check({checksumMismatchFlag, truncatedTransactionFlag}, 0);
      check(ramAddr, 12'hffc);
      $display("test foreign command done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      clk            = 1'b0;
      rstn           = 1'b0;
      clearMismatch  = 1'b0;
      clearTruncated = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check({ramWrEn, checksumMismatchFlag, truncatedTransactionFlag}, 0);
      t_good();
      t_bad();
      t_trunc();
      t_other();
      results();
   end

   initial begin
      #100000;
      bad_count++;
      results();
   end
endmodule // testbench

`default_nettype wire
